/* File: hw/ledsc_decoder.sv */
// Top of the LED serial command decoder: frame decode, routing and output update.
`timescale 1ns/1ns
`default_nettype none
`include "ledsc_defs.svh"
module ledsc_decoder (
   input  wire logic                         clock,
   input  wire logic                         rst_b,
   input  wire logic                         sclk,
   input  wire logic                         select_n,
   input  wire logic                         serial_in,
   input  wire logic [4:0]                   chip_id_straps,
   output wire ledsc_pkg::ledsc_grade_type [4:0] red_outputs,
   output wire ledsc_pkg::ledsc_grade_type [4:0] green_outputs,
   output wire ledsc_pkg::ledsc_grade_type [4:0] blue_outputs,
   output logic                              pwm_stop,
   output logic                              test_lock,
   output logic                              frame_active
);
   import ledsc_pkg::*;

   ledsc_event_type            link_ev;
   logic                       link_tog;
   logic                       sel_s1_r, sel_s2_r, sel_s3_r, sel_s4_r;
   logic                       tog_s1_r, tog_s2_r, tog_s3_r;
   logic [4:0]                 strap_s1_r, strap_s2_r;
   ledsc_state_type            state_r;
   logic [3:0]                 instr_r;
   ledsc_cmd_type              cmd_r;
   ledsc_cmd_type              cmd_in;
   logic                       head_seen_r;
   logic [4:0]                 byte_cnt_r;
   logic [14:0]                dirty_r;
   logic                       prohib_prev_r;
   ledsc_grade_type [14:0]     disp_r;
   ledsc_grade_type [14:0]     staged;
   logic [14:0]                stored_seen;
   logic                       ev_stb;
   logic                       frame_end;
   logic                       frame_start;
   logic                       wr_en;
   logic [14:0]                wr_mask;
   logic                       addr_hit;
   logic                       prohib;
   logic                       do_latch;
   logic                       do_normal;
   logic                       stop_cmd;

   ledsc_link u_link (
      .sclk      (sclk),
      .rst_b     (rst_b),
      .select_n  (select_n),
      .serial_in (serial_in),
      .ev_toggle (link_tog),
      .ev        (link_ev)
   );

   ledsc_store u_store (
      .clock   (clock),
      .rst_b   (rst_b),
      .wr_en   (wr_en),
      .wr_mask (wr_mask),
      .wr_data (link_ev.data[7:0]),
      .rd_data (staged),
      .seen    (stored_seen)
   );

   // Select takes one stage more than the event toggle, so the last byte is
   // always handled before the frame is closed.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         sel_s1_r <= 1'b1;
         sel_s2_r <= 1'b1;
         sel_s3_r <= 1'b1;
         sel_s4_r <= 1'b1;
      end else begin
         sel_s1_r <= select_n;
         sel_s2_r <= sel_s1_r;
         sel_s3_r <= sel_s2_r;
         sel_s4_r <= sel_s3_r;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         tog_s1_r <= 1'b0;
         tog_s2_r <= 1'b0;
         tog_s3_r <= 1'b0;
      end else begin
         tog_s1_r <= link_tog;
         tog_s2_r <= tog_s1_r;
         tog_s3_r <= tog_s2_r;
      end
   end

   // The straps are static pins, synchronised in every cycle and compared at each command event, also inside a frame.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         strap_s1_r <= 5'h00;
         strap_s2_r <= 5'h00;
      end else begin
         strap_s1_r <= chip_id_straps;
         strap_s2_r <= strap_s1_r;
      end
   end

   assign ev_stb      = tog_s2_r ^ tog_s3_r;
   assign frame_end   = sel_s3_r & ~sel_s4_r;
   assign frame_start = ~sel_s2_r & sel_s3_r;
   assign cmd_in      = ledsc_cmd_type'(link_ev.data);
   assign addr_hit    = (cmd_in.addr == strap_s2_r) && !test_lock;
   assign prohib      = (cmd_in.sel < `LEDSC_SEL_SET_LO) || (cmd_in.sel > `LEDSC_SEL_FILL);

   function automatic logic [14:0] route_mask(input ledsc_cmd_type c, input logic [4:0] n);
      logic [14:0] m;
      logic [3:0]  idx;
      logic [3:0]  base;
      logic [3:0]  color;
      m     = 15'h0000;
      base  = 4'(`LEDSC_SEL_SET_HI - c.sel);
      color = 4'(c.sel - `LEDSC_SEL_RED);
      idx   = 4'h0;
      if (c.every_set) begin
         if (n < `LEDSC_ALL_BYTES) begin
            idx    = n[3:0];
            m[idx] = 1'b1;
         end
      end else if (c.sel >= `LEDSC_SEL_SET_LO && c.sel <= `LEDSC_SEL_SET_HI) begin
         if (n < `LEDSC_SET_BYTES) begin
            idx    = 4'(base * 4'd3 + n[3:0]);
            m[idx] = 1'b1;
         end
      end else if (c.sel >= `LEDSC_SEL_RED && c.sel <= `LEDSC_SEL_BLUE) begin
         if (n < `LEDSC_LINE_BYTES) begin
            idx    = 4'(n[3:0] * 4'd3 + color);
            m[idx] = 1'b1;
         end
      end else if (c.sel == `LEDSC_SEL_LINES) begin
         if (n < `LEDSC_LINE_BYTES) begin
            idx = 4'(n[3:0] * 4'd3);
            m   = 15'(15'h0007 << idx);
         end
      end else if (c.sel == `LEDSC_SEL_FILL) begin
         m = 15'h7fff;
      end
      return m;
   endfunction : route_mask

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         state_r <= LS_IDLE;
      end else if (frame_end) begin
         state_r <= LS_IDLE;
      end else if (ev_stb) begin
         unique case (link_ev.kind)
            LE_INSTR: state_r <= LS_HEAD;
            LE_CMD: begin
               // A latch frame carries no valid command field beyond its instruction.
               if (addr_hit && instr_r != `LEDSC_INSTR_LATCH) begin
                  state_r <= LS_DATA;
               end else begin
                  state_r <= LS_SKIP;
               end
            end
            LE_BYTE: state_r <= state_r;
            default: state_r <= LS_SKIP;
         endcase
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         instr_r     <= `LEDSC_INSTR_LATCH;
         head_seen_r <= 1'b0;
         cmd_r       <= '0;
      end else if (frame_end) begin
         head_seen_r <= 1'b0;
      end else if (ev_stb && link_ev.kind == LE_INSTR) begin
         instr_r     <= link_ev.data[3:0];
         head_seen_r <= 1'b1;
      end else if (ev_stb && link_ev.kind == LE_CMD) begin
         cmd_r <= cmd_in;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         byte_cnt_r <= 5'h00;
      end else if (ev_stb && link_ev.kind == LE_CMD) begin
         byte_cnt_r <= 5'h00;
      end else if (ev_stb && link_ev.kind == LE_BYTE && byte_cnt_r != `LEDSC_CNT_MAX) begin
         byte_cnt_r <= byte_cnt_r + 5'h01;
      end
   end

   // Read frames are accepted but nothing is driven back; only writes reach the store.
   assign wr_en = ev_stb && link_ev.kind == LE_BYTE && state_r == LS_DATA && cmd_r.write_dir
                  && (instr_r == `LEDSC_INSTR_NORM || instr_r == `LEDSC_INSTR_UNREF);
   assign wr_mask = route_mask(cmd_r, byte_cnt_r);

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         dirty_r <= 15'h0000;
      end else if (frame_start) begin
         dirty_r <= 15'h0000;
      end else if (wr_en) begin
         dirty_r <= dirty_r | wr_mask;
      end
   end

   // Once locked only a reset frees the device, standing in for a power cycle.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         prohib_prev_r <= 1'b0;
         test_lock     <= 1'b0;
      end else if (ev_stb && link_ev.kind == LE_CMD && addr_hit
                   && instr_r != `LEDSC_INSTR_LATCH) begin
         prohib_prev_r <= prohib && !cmd_in.every_set;
         if (prohib && !cmd_in.every_set && prohib_prev_r) begin
            test_lock <= 1'b1;
         end
      end
   end

   assign do_latch  = frame_end && head_seen_r && instr_r == `LEDSC_INSTR_LATCH && !test_lock;
   assign do_normal = frame_end && state_r == LS_DATA && instr_r == `LEDSC_INSTR_NORM
                      && cmd_r.write_dir;
   assign stop_cmd  = do_normal && cmd_r.every_set && cmd_r.out_stop;

   genvar k;
   generate
      for (k = 0; k < `LEDSC_NUM_ENTRY; k++) begin : g_disp
         always_ff @(posedge clock) begin
            if (!rst_b) begin
               disp_r[k] <= `LEDSC_GRADE_OFF;
            end else if (do_latch) begin
               disp_r[k] <= stored_seen[k] ? staged[k] : `LEDSC_GRADE_OFF;
            end else if (do_normal && dirty_r[k]) begin
               disp_r[k] <= staged[k];
            end
         end
      end
      for (k = 0; k < 5; k++) begin : g_pins
         assign red_outputs[k]   = disp_r[(4 - k) * 3];
         assign green_outputs[k] = disp_r[(4 - k) * 3 + 1];
         assign blue_outputs[k]  = disp_r[(4 - k) * 3 + 2];
      end
   endgenerate

   // Stop keeps the gradation data; a later latch relights with the same values.
   always_ff @(posedge clock) begin
      if (!rst_b) begin
         pwm_stop <= 1'b0;
      end else if (stop_cmd) begin
         pwm_stop <= 1'b1;
      end else if (do_latch) begin
         pwm_stop <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (!rst_b) begin
         frame_active <= 1'b0;
      end else begin
         frame_active <= ~sel_s2_r;
      end
   end

   logic [7:0] staged_e0;
   logic [7:0] staged_e1;
   logic       stop_bits;
   assign staged_e0 = staged[0];
   assign staged_e1 = staged[1];
   assign stop_bits = cmd_r.write_dir & cmd_r.every_set & cmd_r.out_stop;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_b);

   sequence latch_close;
      frame_end && head_seen_r && instr_r == `LEDSC_INSTR_LATCH && !test_lock;
   endsequence
   sequence short_close;
      latch_close ##0 state_r == LS_HEAD;
   endsequence
   sequence normal_close;
      frame_end && state_r == LS_DATA && instr_r == `LEDSC_INSTR_NORM && cmd_r.write_dir;
   endsequence

   latch_blank_a: assert property (latch_close ##0 !stored_seen[0]
      |=> red_outputs[4] == 8'h00)
      else $error("Unwritten output not turned off by latch.");
   latch_apply_a: assert property (latch_close ##0 stored_seen[0]
      |=> disp_r[0] == $past(staged_e0))
      else $error("Latch did not apply stored data.");
   short_latch_a: assert property (short_close |=> !pwm_stop)
      else $error("Shortened latch frame not accepted.");
   normal_apply_a: assert property (normal_close ##0 dirty_r[1]
      |=> disp_r[1] == $past(staged_e1))
      else $error("Normal command did not update the output.");
   unref_hold_a: assert property (frame_end && instr_r == `LEDSC_INSTR_UNREF
      |=> $stable(disp_r))
      else $error("Unreflected command changed the outputs.");
   addr_skip_a: assert property (ev_stb && link_ev.kind == LE_CMD
      && cmd_in.addr != strap_s2_r |=> state_r == LS_SKIP)
      else $error("Command for another address was not ignored.");
   stop_set_a: assert property (normal_close ##0 stop_bits |=> pwm_stop)
      else $error("Output stop not applied.");
   stop_cause_a: assert property ($rose(pwm_stop) |-> $past(stop_bits))
      else $error("Output stopped without all three bits set.");
   all_route_a: assert property (wr_en && cmd_r.every_set
      |-> wr_mask == 15'(15'h0001 << byte_cnt_r[3:0]) || byte_cnt_r >= `LEDSC_ALL_BYTES)
      else $error("Every-set write misrouted.");
   set_route_a: assert property (wr_en && !cmd_r.every_set && cmd_r.sel == 4'h7
      && byte_cnt_r == 5'h00 |-> wr_mask == 15'h0008)
      else $error("Set seven red byte misrouted.");
   color_route_a: assert property (wr_en && !cmd_r.every_set && cmd_r.sel == 4'ha
      && byte_cnt_r == 5'h01 |-> wr_mask == 15'h0010)
      else $error("Green line write misrouted.");
   line_route_a: assert property (wr_en && !cmd_r.every_set && cmd_r.sel == `LEDSC_SEL_LINES
      && byte_cnt_r == 5'h00 |-> wr_mask == 15'h0007)
      else $error("Line write did not hit all three colours.");
   fill_route_a: assert property (wr_en && !cmd_r.every_set && cmd_r.sel == `LEDSC_SEL_FILL
      |-> wr_mask == 15'h7fff)
      else $error("Fill write missed some outputs.");
   prohib_lock_a: assert property (ev_stb && link_ev.kind == LE_CMD && addr_hit && prohib
      && !cmd_in.every_set && prohib_prev_r && instr_r != `LEDSC_INSTR_LATCH |=> test_lock)
      else $error("Repeated prohibited code did not lock.");
endmodule : ledsc_decoder
`default_nettype wire

/* File: hw/ledsc_defs.svh */
// Constants of the LED serial command decoder: frame layout, codes and sizes.
// Overview of operation
// - A frame opens with 16 bits: instruction, chip address, direction, every-set, stop, lines.
// - The chip address comes from the straps; only matching commands execute, except latch, which ignores the address.
// - Normal command shows newly written gradation data when select_n rises.
// - Unreflected command stores gradation data without changing the lit outputs.
// - Latch command applies all stored gradation data at once on select_n rising.
// - Latch turns off every output that never received gradation data.
// - A latch frame may end right after its 4-bit instruction.
// - Line codes 0100 to 1000 address RGB sets 4 to 8, red first.
// - Codes 1001, 1010, 1011 write red, green or blue lines 8 down to 4.
// - Code 1100 writes each byte to red, green and blue of one line.
// - Code 1101 writes the same byte to every output.
// - Prohibited line codes used twice in a row lock the device in test.
// - A command other than latch whose address differs from the straps is ignored.
// - Every-set overrides the line field and addresses all RGB sets.
// - Output stop acts only when direction, every-set and stop are all one.
`ifndef LEDSC_DEFS_SVH
`define LEDSC_DEFS_SVH
`define LEDSC_INSTR_BITS  8'd4
`define LEDSC_CMD_BITS    8'd16
`define LEDSC_CNT_CAP     8'hf8
`define LEDSC_INSTR_LATCH 4'h0
`define LEDSC_INSTR_UNREF 4'h1
`define LEDSC_INSTR_NORM  4'h2
`define LEDSC_SEL_SET_LO  4'h4
`define LEDSC_SEL_SET_HI  4'h8
`define LEDSC_SEL_RED     4'h9
`define LEDSC_SEL_BLUE    4'hb
`define LEDSC_SEL_LINES   4'hc
`define LEDSC_SEL_FILL    4'hd
`define LEDSC_NUM_ENTRY   15
`define LEDSC_SET_BYTES   5'd3
`define LEDSC_LINE_BYTES  5'd5
`define LEDSC_ALL_BYTES   5'd15
`define LEDSC_CNT_MAX     5'h1f
`define LEDSC_GRADE_OFF   8'h00
`endif

/* File: hw/ledsc_pkg.sv */
// Types shared by the LED serial command decoder files.
package ledsc_pkg;
   typedef enum logic [1:0] {LE_INSTR, LE_CMD, LE_BYTE} ledsc_kind_type;
   typedef struct packed {
      ledsc_kind_type kind;
      logic [15:0]    data;
   } ledsc_event_type;
   typedef struct packed {
      logic [3:0] instr;
      logic [4:0] addr;
      logic       write_dir;
      logic       every_set;
      logic       out_stop;
      logic [3:0] sel;
   } ledsc_cmd_type;
   typedef enum logic [1:0] {LS_IDLE, LS_HEAD, LS_DATA, LS_SKIP} ledsc_state_type;
   typedef logic [7:0] ledsc_grade_type;
endpackage : ledsc_pkg

/* File: hw/ledsc_link.sv */
// Serial clock side: shifts frame bits and posts instruction, command and byte events.
`timescale 1ns/1ns
`default_nettype none
`include "ledsc_defs.svh"
module ledsc_link (
   input  wire logic                sclk,
   input  wire logic                rst_b,
   input  wire logic                select_n,
   input  wire logic                serial_in,
   output logic                     ev_toggle,
   output ledsc_pkg::ledsc_event_type ev
);
   import ledsc_pkg::*;
   logic [7:0]  cnt_r;
   logic [14:0] sh_r;
   logic [7:0]  cnt_nxt;

   assign cnt_nxt = cnt_r + 8'd1;

   // The serial clock stops between frames, so select_n high clears the frame position.
   always_ff @(posedge sclk or posedge select_n) begin
      if (select_n) begin
         cnt_r <= 8'h00;
         sh_r  <= 15'h0000;
      end else begin
         sh_r <= {sh_r[13:0], serial_in};
         if (cnt_r != `LEDSC_CNT_CAP) begin
            cnt_r <= cnt_nxt;
         end
      end
   end

   // Each payload stays put for at least eight serial clocks, far longer than the crossing.
   always_ff @(posedge sclk or negedge rst_b) begin
      if (!rst_b) begin
         ev_toggle <= 1'b0;
         ev        <= '{kind: LE_INSTR, data: 16'h0000};
      end else if (!select_n && cnt_r != `LEDSC_CNT_CAP) begin
         if (cnt_nxt == `LEDSC_INSTR_BITS) begin
            ev        <= '{kind: LE_INSTR, data: {12'h000, sh_r[2:0], serial_in}};
            ev_toggle <= ~ev_toggle;
         end else if (cnt_nxt == `LEDSC_CMD_BITS) begin
            ev        <= '{kind: LE_CMD, data: {sh_r, serial_in}};
            ev_toggle <= ~ev_toggle;
         end else if (cnt_nxt > `LEDSC_CMD_BITS && cnt_nxt[2:0] == 3'h0) begin
            ev        <= '{kind: LE_BYTE, data: {8'h00, sh_r[6:0], serial_in}};
            ev_toggle <= ~ev_toggle;
         end
      end
   end

   cmd_event_a: assert property (@(posedge sclk) disable iff (select_n || !rst_b)
      cnt_r == 8'd15 |=> ev.kind == LE_CMD && ev.data[0] == $past(serial_in))
      else $error("Command event missing after sixteen bits.");
   msb_first_a: assert property (@(posedge sclk) disable iff (select_n || !rst_b)
      cnt_r == 8'd3 |=> ev.data[3] == $past(sh_r[2]))
      else $error("Instruction bits not taken most significant first.");
endmodule : ledsc_link
`default_nettype wire

/* File: hw/ledsc_store.sv */
// Stored gradation bytes for all fifteen outputs, with registered read data.
`timescale 1ns/1ns
`default_nettype none
`include "ledsc_defs.svh"
module ledsc_store (
   input  wire logic                                  clock,
   input  wire logic                                  rst_b,
   input  wire logic                                  wr_en,
   input  wire logic [14:0]                           wr_mask,
   input  wire logic [7:0]                            wr_data,
   output ledsc_pkg::ledsc_grade_type [14:0]          rd_data,
   output logic [14:0]                                seen
);
   import ledsc_pkg::*;
   genvar k;
   generate
      for (k = 0; k < `LEDSC_NUM_ENTRY; k++) begin : g_entry
         always_ff @(posedge clock) begin
            if (!rst_b) begin
               rd_data[k] <= `LEDSC_GRADE_OFF;
               seen[k]    <= 1'b0;
            end else if (wr_en && wr_mask[k]) begin
               rd_data[k] <= wr_data;
               seen[k]    <= 1'b1;
            end
         end
      end
   endgenerate

   store_write_a: assert property (@(posedge clock) disable iff (!rst_b)
      wr_en && wr_mask[0] |=> rd_data[0] == $past(wr_data) && seen[0])
      else $error("Stored byte did not take the written value.");
endmodule : ledsc_store
`default_nettype wire

/* File: dv/ledsc_master.sv */
// Serial bus master model that sends command frames and gradation bytes.
`timescale 1ns/1ns
`default_nettype none
module ledsc_master (
   output logic sclk,
   output logic select_n,
   output logic serial_in
);
   initial begin
      sclk      = 1'b0;
      serial_in = 1'b0;
      // Unknown for a moment so the link sees select_n rise and clears its frame position.
      #1 select_n = 1'b1;
   end
   task automatic bit_out(input logic v);
      serial_in = v;
      #15 sclk = 1'b1;
      #15 sclk = 1'b0;
   endtask : bit_out
   // The serial clock only runs inside a frame; a gap stretches the frame for slow-master cases.
   task automatic send(input logic [15:0] head, input int nhead, input logic [7:0] q[$],
                       input int gap);
      logic [7:0] b;
      select_n = 1'b0;
      #60;
      for (int i = 15; i >= 16 - nhead; i--) bit_out(head[i]);
      foreach (q[j]) begin
         b = q[j];
         for (int i = 7; i >= 0; i--) bit_out(b[i]);
         #(gap);
      end
      #300;
      select_n  = 1'b1;
      // Released data line shows the inverse so a stale bit is never mistaken for data.
      serial_in = ~serial_in;
      #2100;
   endtask : send
endmodule : ledsc_master
`default_nettype wire

/* File: dv/ledsc_decoder_tb_top.sv */
// Self-checking bench for the LED serial command decoder.
`timescale 1ns/1ns
`default_nettype none
module ledsc_decoder_tb_top;
   import ledsc_pkg::*;
   logic                  clock, rst_b, sclk, select_n, serial_in, pwm_stop, test_lock;
   logic                  frame_active, exp_stop, exp_lock, last_bad, dir_w;
   logic [4:0]            chip_id_straps;
   ledsc_grade_type [4:0] red_outputs, green_outputs, blue_outputs;
   ledsc_grade_type       shown [3][5];
   ledsc_grade_type       store [3][5];
   logic [14:0]           seen_m;
   logic [31:0]           rnd;
   int                    failures, comparisons;
   ledsc_decoder ledsc_decoder_inst (.clock(clock), .rst_b(rst_b), .sclk(sclk),
      .select_n(select_n), .serial_in(serial_in), .chip_id_straps(chip_id_straps),
      .red_outputs(red_outputs), .green_outputs(green_outputs), .blue_outputs(blue_outputs),
      .pwm_stop(pwm_stop), .test_lock(test_lock), .frame_active(frame_active));
   ledsc_master ledsc_master_inst (.sclk(sclk), .select_n(select_n), .serial_in(serial_in));
   always #25 clock = ~clock;
   function automatic logic [31:0] next_rnd(input logic [31:0] x);
      return (x >> 1) ^ (x[0] ? 32'h80200003 : 32'h0);
   endfunction : next_rnd
   // Entry e is line 8 - e/3, colour e%3 (red, green, blue).
   function automatic logic [14:0] route(input logic [3:0] sel, input logic every, input int i);
      logic [14:0] m;
      m = '0;
      if (every) begin if (i < 15) m[i] = 1'b1; end
      else if (sel >= 4'h4 && sel <= 4'h8) begin if (i < 3) m[(8 - sel) * 3 + i] = 1'b1; end
      else if (sel >= 4'h9 && sel <= 4'hb) begin if (i < 5) m[i * 3 + sel - 9] = 1'b1; end
      else if (sel == 4'hc) begin if (i < 5) m[i * 3 +: 3] = 3'h7; end
      else if (sel == 4'hd) m = 15'h7fff;
      return m;
   endfunction : route
   task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic verify(input string tname);
      for (int k = 0; k < 5; k++) begin
         check("red_outputs", red_outputs[k], shown[0][k]);
         check("green_outputs", green_outputs[k], shown[1][k]);
         check("blue_outputs", blue_outputs[k], shown[2][k]);
      end
      check("pwm_stop", {7'h0, pwm_stop}, {7'h0, exp_stop});
      check("test_lock", {7'h0, test_lock}, {7'h0, exp_lock});
      check("frame_active", {7'h0, frame_active}, 8'h00);
      $display("test %s done", tname);
   endtask : verify
   task automatic do_reset;
      @(posedge clock) #2 rst_b = 1'b0;
      repeat (12) @(posedge clock);
      #2 rst_b = 1'b1;
      for (int e = 0; e < 15; e++) begin
         shown[e % 3][4 - e / 3] = 8'h00;
         store[e % 3][4 - e / 3] = 8'h00;
      end
      {seen_m, exp_stop, exp_lock, last_bad} = '0;
      repeat (4) @(posedge clock);
   endtask : do_reset
   task automatic frame(input logic [3:0] instr, input logic [4:0] addr, input logic every,
                        input logic stop, input logic [3:0] sel, input int n, input int nhead);
      logic [7:0]  q[$];
      logic [14:0] m, done;
      logic        hit, bad, wr;
      q = {};
      done = '0;
      hit = (addr === chip_id_straps || instr == 4'h0) && !exp_lock;
      bad = !every && (sel < 4'h4 || sel > 4'hd);
      wr = hit && dir_w;
      for (int i = 0; i < n; i++) begin
         rnd = next_rnd(rnd);
         q.push_back(rnd[7:0]);
         m = route(sel, every, i);
         for (int e = 0; e < 15; e++) if (m[e] && wr && instr != 4'h0) begin
            store[e % 3][4 - e / 3] = rnd[7:0];
            seen_m[e] = 1'b1;
            done[e] = 1'b1;
         end
      end
      for (int e = 0; e < 15; e++) begin
         if (wr && instr == 4'h2 && done[e]) shown[e % 3][4 - e / 3] = store[e % 3][4 - e / 3];
         if (hit && instr == 4'h0)
            shown[e % 3][4 - e / 3] = seen_m[e] ? store[e % 3][4 - e / 3] : 8'h00;
      end
      if (hit && instr == 4'h0) exp_stop = 1'b0;
      if (wr && instr == 4'h2 && every && stop) exp_stop = 1'b1;
      if (hit && instr != 4'h0) begin
         if (bad && last_bad) exp_lock = 1'b1;
         last_bad = bad;
      end
      @(posedge clock) #2;
      fork
         ledsc_master_inst.send({instr, addr, dir_w, every, stop, sel}, nhead, q,
                                rnd[8] ? 400 : 0);
         begin
            repeat (8) @(posedge clock);
            #2 check("frame_active", {7'h0, frame_active}, 8'h01);
         end
      join
      verify($sformatf("instr %h sel %h every %b stop %b", instr, sel, every, stop));
   endtask : frame
   task automatic conclude;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : conclude
   initial begin
      #1000000;
      failures++;
      conclude();
   end
   initial begin
      clock = 1'b0;
      rst_b = 1'b1;
      dir_w = 1'b1;
      failures = 0;
      comparisons = 0;
      rnd = next_rnd(32'd68567);
      chip_id_straps = rnd[4:0];
      do_reset();
      verify("reset");
      for (int s = 4; s <= 13; s++) frame(4'h2, chip_id_straps, 1'b0, 1'b0, s[3:0],
                                        s <= 8 ? 3 : (s == 13 ? 2 : 5), 16);
      frame(4'h2, chip_id_straps, 1'b1, 1'b0, 4'h0, 15, 16);
      frame(4'h2, ~chip_id_straps, 1'b0, 1'b0, 4'h6, 3, 16);
      @(posedge clock) #2 chip_id_straps = chip_id_straps + 5'h01;
      frame(4'h2, chip_id_straps, 1'b0, 1'b1, 4'h5, 3, 16);
      dir_w = 1'b0;
      frame(4'h2, chip_id_straps, 1'b1, 1'b1, 4'h0, 15, 16);
      dir_w = 1'b1;
      frame(4'h2, chip_id_straps, 1'b1, 1'b1, 4'h0, 0, 16);
      frame(4'h0, 5'h0, 1'b0, 1'b0, 4'h0, 0, 4);
      do_reset();
      frame(4'h1, chip_id_straps, 1'b0, 1'b0, 4'h5, 3, 16);
      frame(4'h0, ~chip_id_straps, 1'b0, 1'b0, 4'h0, 0, 4);
      frame(4'h2, chip_id_straps, 1'b0, 1'b0, 4'h0, 3, 16);
      frame(4'h2, chip_id_straps, 1'b0, 1'b0, 4'hf, 3, 16);
      frame(4'h2, chip_id_straps, 1'b0, 1'b0, 4'h8, 3, 16);
      conclude();
   end
endmodule : ledsc_decoder_tb_top
`default_nettype wire
